/* File: src/boot_strap_defines.svh */
// Offsets, strap codes, clock selections and timing for the strap loader.
// Assumes inclusion by bare name from the strap loader design file.
`ifndef BOOT_STRAP_DEFINES_SVH
`define BOOT_STRAP_DEFINES_SVH

// Three-level strap reading, two bits per strap
`define TRIT_LO      2'h0
`define TRIT_HI      2'h1
`define TRIT_FL      2'h2

// Boot-mode strap codes, strap 2 in the top pair
`define PM_F00       6'h20
`define PM_F01       6'h21
`define PM_F11       6'h25
`define PM_F0F       6'h22
`define PM_F1F       6'h26
`define PM_1FF       6'h1a
`define PM_0F1       6'h09

// Reference frequency strap codes
`define FS_XTAL      3'h0
`define FS_EXT19     3'h4
`define FS_EXT26     3'h5
`define FS_EXT38     3'h6
`define FS_EXT52     3'h7

// PLL: reference over predivider gives 0.4 MHz, times 1000 is 400 MHz
`define PLL_MULT_VAL 10'h3e8
`define PREDIV_19    8'h30
`define PREDIV_26    8'h41
`define PREDIV_38    8'h60
`define PREDIV_52    8'h82

// Register byte offsets and fields
`define REG_CTRL     8'h00
`define REG_STAT     8'h04
`define CTRL_CPU_BIT 0
`define CTRL_DEV_BIT 1
`define HSIZE_WORD   3'h2
`define HTRANS_ACT   1

// Timing: soft reset pulse length and the clock period
`define SOFT_RST_NS  1000
`define CLK_PERIOD_NS 100

`endif

/* File: src/boot_strap_pkg.sv */
// Types shared by the strap loader and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package boot_strap_pkg;

    // Boot source chosen from the boot-mode straps
    typedef enum logic [2:0] {
        BOOT_SYNC_MUX,
        BOOT_ASYNC_MUX,
        BOOT_ASYNC_SRAM,
        BOOT_USB,
        BOOT_I2C,
        BOOT_SPI
    } boot_src_t;

    // Configuration handed to the boot loader and the PLL
    typedef struct packed {
        boot_src_t   source;       // Boot source
        logic        usb_fallback; // USB boot if source fails
        logic        ref_crystal;  // Crystal oscillator in use
        logic        ref_valid;    // Frequency straps were legal
        logic [9:0]  pll_mult;     // PLL feedback multiplier
        logic [7:0]  pll_prediv;   // PLL reference predivider
    } boot_cfg_t;

    // Captured straps
    typedef struct packed {
        logic [2:0]  freq;         // Frequency-select straps
        logic [5:0]  boot;         // Boot-mode straps, two bits each
    } strap_cap_t;

    // Bus address phase held for the data phase
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
    } ahb_req_t;

endpackage : boot_strap_pkg

/* File: src/boot_strap_reset_clock_select.sv */
// Strap loader: boot source and reference clock decode, hard and soft
// reset sequencing, with an AHB-Lite register slave.
// Assumes SYS_CLK at 10 MHz and straps stable around hard reset release.
//
// Notes on behaviour
// - Three-level boot straps select parallel or USB boot
// - I2C and SPI boot codes, some with USB fallback
// - Hard reset held means all pins high impedance
// - Hard reset release starts loader with decoded source
// - Control register bits request CPU or device reset
// - CPU reset keeps memory, firmware stays loaded
// - Device soft reset acts exactly as hard reset
// - Frequency straps pick crystal or external clock rate
// - PLL factors follow reference, core rate fixed
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "boot_strap_defines.svh"

module boot_strap_reset_clock_select #(
    parameter int SOFT_RST_CYCLES =
        (`SOFT_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire logic                   SYS_CLK,
    input  wire logic                   RST,
    input  wire logic                   HARD_RESET_N,
    input  wire logic [2:0]             BOOT_MODE_STRAPS_PU,
    input  wire logic [2:0]             BOOT_MODE_STRAPS_PD,
    input  wire logic [2:0]             REF_FREQ_SELECT_STRAPS,
    input  wire logic                   HSEL,
    input  wire logic [31:0]            HADDR,
    input  wire logic [1:0]             HTRANS,
    input  wire logic                   HWRITE,
    input  wire logic [2:0]             HSIZE,
    input  wire logic [31:0]            HWDATA,
    input  wire logic                   HREADY,
    output logic      [31:0]            HRDATA,
    output logic                        HREADYOUT,
    output logic                        HRESP,
    output logic                        CPU_RESET,
    output logic                        MEM_CLEAR,
    output logic                        IO_HIZ,
    output logic                        BOOT_START,
    output boot_strap_pkg::boot_cfg_t   BOOT_CFG
);

    localparam int CW = $clog2(SOFT_RST_CYCLES + 1);

    // Refuse pulse lengths the counters and checks cannot serve
    if (SOFT_RST_CYCLES < 2 || SOFT_RST_CYCLES > 255)
    begin : g_bad_len
        $error("SOFT_RST_CYCLES out of range");
    end

    // Pins from outside: reset pin, both strap readings, frequency
    logic [9:0]  pin_raw;                 // Raw pin vector
    logic [9:0]  meta_reg;                // First synchroniser stage
    logic [9:0]  sync_reg;                // Second synchroniser stage
    logic [5:0]  trit;                    // Decoded boot strap levels

    assign pin_raw = {HARD_RESET_N, BOOT_MODE_STRAPS_PU,
                      BOOT_MODE_STRAPS_PD, REF_FREQ_SELECT_STRAPS};

    // Two-stage synchroniser, second stage is the only reader
    always_ff @(posedge SYS_CLK)
    begin
        meta_reg <= pin_raw;
        sync_reg <= meta_reg;
    end

    // Strap reading with pull-up high and pull-down low means floating
    for (genvar i = 0; i < 3; i++)
    begin : g_trit
        logic pu;
        logic pd;
        assign pu = sync_reg[6 + i];
        assign pd = sync_reg[3 + i];
        assign trit[2*i +: 2] = (pu && pd)   ? `TRIT_HI :
                                (!pu && !pd) ? `TRIT_LO :
                                               `TRIT_FL;
    end

    // Reset sequencing state
    logic           hard_active;          // Hard reset pin held
    logic           glob;                 // Hard or device reset active
    logic [CW-1:0]  dev_cnt_reg;          // Device soft reset countdown
    logic [CW-1:0]  dev_cnt_next;
    logic [CW-1:0]  cpu_cnt_reg;          // CPU soft reset countdown
    logic [CW-1:0]  cpu_cnt_next;
    logic           glob_prev_reg;        // Last cycle's reset state
    logic           release_now;          // Reset ends this cycle
    logic           cpu_fire;             // Write asks CPU reset
    logic           dev_fire;             // Write asks device reset
    logic           ctrl_wr;              // Data phase write to control

    // Captured straps and decoded configuration
    boot_strap_pkg::strap_cap_t cap_reg;
    boot_strap_pkg::strap_cap_t cap_next;
    boot_strap_pkg::boot_cfg_t  cfg_reg;
    boot_strap_pkg::boot_cfg_t  cfg_next;
    boot_strap_pkg::boot_cfg_t  dec;      // Live decode of straps

    // Output flops
    logic cpu_rst_reg, cpu_rst_next;
    logic mem_clr_reg, mem_clr_next;
    logic io_hiz_reg,  io_hiz_next;
    logic boot_go_reg, boot_go_next;

    // Bus slave state
    boot_strap_pkg::ahb_req_t req_reg;
    boot_strap_pkg::ahb_req_t req_next;
    logic [31:0]              rdata_reg;
    logic [31:0]              rdata_next;
    logic [31:0]              stat_word;  // Status register image
    logic [31:0]              ctrl_word;  // Control register image

    assign hard_active = !sync_reg[9];
    assign glob        = hard_active || (dev_cnt_reg != '0);
    assign release_now = glob_prev_reg && !glob;
    assign ctrl_wr     = req_reg.valid && req_reg.write &&
                         (req_reg.addr == `REG_CTRL) && !glob;
    assign cpu_fire    = ctrl_wr && HWDATA[`CTRL_CPU_BIT];
    assign dev_fire    = ctrl_wr && HWDATA[`CTRL_DEV_BIT];

    // Decode the live straps into a boot and clock configuration
    always_comb
    begin
        dec              = '0;
        dec.source       = boot_strap_pkg::BOOT_USB;
        dec.pll_mult     = `PLL_MULT_VAL;
        dec.ref_valid    = 1'b1;
        // Boot source from the three-level straps
        case (trit)
            `PM_F00: dec.source = boot_strap_pkg::BOOT_SYNC_MUX;
            `PM_F01: dec.source = boot_strap_pkg::BOOT_ASYNC_MUX;
            `PM_F0F: dec.source = boot_strap_pkg::BOOT_ASYNC_SRAM;
            `PM_F11: dec.source = boot_strap_pkg::BOOT_USB;
            `PM_F1F:
            begin
                dec.source       = boot_strap_pkg::BOOT_I2C;
                dec.usb_fallback = 1'b1;
            end
            `PM_1FF: dec.source = boot_strap_pkg::BOOT_I2C;
            `PM_0F1:
            begin
                dec.source       = boot_strap_pkg::BOOT_SPI;
                dec.usb_fallback = 1'b1;
            end
            // Unlisted codes fall back to USB boot
            default: dec.source = boot_strap_pkg::BOOT_USB;
        endcase
        // Reference clock and PLL predivider from the frequency straps
        case (sync_reg[2:0])
            `FS_XTAL:
            begin
                dec.ref_crystal = 1'b1;
                dec.pll_prediv  = `PREDIV_19;
            end
            `FS_EXT19: dec.pll_prediv = `PREDIV_19;
            `FS_EXT26: dec.pll_prediv = `PREDIV_26;
            `FS_EXT38: dec.pll_prediv = `PREDIV_38;
            `FS_EXT52: dec.pll_prediv = `PREDIV_52;
            // Illegal setting: crystal timing, flagged invalid
            default:
            begin
                dec.ref_crystal = 1'b1;
                dec.pll_prediv  = `PREDIV_19;
                dec.ref_valid   = 1'b0;
            end
        endcase
    end

    // Next values for reset sequencing, capture and outputs
    always_comb
    begin
        dev_cnt_next = dev_cnt_reg;
        cpu_cnt_next = cpu_cnt_reg;
        cap_next     = cap_reg;
        cfg_next     = cfg_reg;
        // Device reset: a timed hard-reset equivalent
        if (hard_active)
            dev_cnt_next = '0;
        else if (dev_fire)
            dev_cnt_next = CW'(SOFT_RST_CYCLES);
        else if (dev_cnt_reg != '0)
            dev_cnt_next = dev_cnt_reg - 1'b1;
        // CPU reset: program counter only
        if (glob)
            cpu_cnt_next = '0;
        else if (cpu_fire)
            cpu_cnt_next = CW'(SOFT_RST_CYCLES);
        else if (cpu_cnt_reg != '0)
            cpu_cnt_next = cpu_cnt_reg - 1'b1;
        // Straps caught once as a full reset ends
        if (release_now)
        begin
            cap_next.freq = sync_reg[2:0];
            cap_next.boot = trit;
            cfg_next      = dec;
        end
        cpu_rst_next = glob || (cpu_cnt_reg != '0);
        mem_clr_next = glob;
        io_hiz_next  = glob;
        boot_go_next = release_now;
    end

    // Register the reset sequencing group
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            dev_cnt_reg   <= '0;
            cpu_cnt_reg   <= '0;
            glob_prev_reg <= 1'b1;
            cap_reg       <= '0;
            cfg_reg       <= '0;
            cpu_rst_reg   <= 1'b1;
            mem_clr_reg   <= 1'b1;
            io_hiz_reg    <= 1'b1;
            boot_go_reg   <= 1'b0;
        end
        else
        begin
            dev_cnt_reg   <= dev_cnt_next;
            cpu_cnt_reg   <= cpu_cnt_next;
            glob_prev_reg <= glob;
            cap_reg       <= cap_next;
            cfg_reg       <= cfg_next;
            cpu_rst_reg   <= cpu_rst_next;
            mem_clr_reg   <= mem_clr_next;
            io_hiz_reg    <= io_hiz_next;
            boot_go_reg   <= boot_go_next;
        end
    end

    // Register images: pending resets, captured straps and decode
    assign ctrl_word = 32'({dev_cnt_reg != '0, cpu_cnt_reg != '0});
    assign stat_word = 32'({cap_reg, cfg_reg.source, cfg_reg.usb_fallback,
                            cfg_reg.ref_crystal, cfg_reg.ref_valid});

    // Bus slave: hold the address phase, prepare read data for the data
    always_comb
    begin
        req_next       = '0;
        rdata_next     = '0;
        req_next.valid = HSEL && HREADY && HTRANS[`HTRANS_ACT] &&
                         (HSIZE == `HSIZE_WORD);
        req_next.write = HWRITE;
        req_next.addr  = HADDR[7:0];
        // Reads answer in the data phase; unmapped reads give zero
        if (req_next.valid && !HWRITE)
        begin
            case (HADDR[7:0])
                `REG_CTRL: rdata_next = ctrl_word;
                `REG_STAT: rdata_next = stat_word;
                default:   rdata_next = '0;
            endcase
        end
    end

    // Register the bus slave group
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            req_reg   <= '0;
            rdata_reg <= '0;
        end
        else
        begin
            req_reg   <= req_next;
            rdata_reg <= rdata_next;
        end
    end

    // Outputs straight from flops; slave is always ready, always OKAY
    assign HRDATA     = rdata_reg;
    assign HREADYOUT  = 1'b1 | RST;
    assign HRESP      = 1'b0 & RST;
    assign CPU_RESET  = cpu_rst_reg;
    assign MEM_CLEAR  = mem_clr_reg;
    assign IO_HIZ     = io_hiz_reg;
    assign BOOT_START = boot_go_reg;
    assign BOOT_CFG   = cfg_reg;

    // Checks on the reset sequencing, strap decode and capture
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    sequence s_dev_req;
        dev_fire;
    endsequence

    sequence s_dev_hold;
        glob [*2] ##1 mem_clr_reg && io_hiz_reg && cpu_rst_reg;
    endsequence

    a_hiz_hard: assert property (hard_active |=> io_hiz_reg)
        else $error("pins not high impedance in hard reset");
    a_boot_start: assert property (
        $fell(glob) |=> BOOT_START ##1 !BOOT_START)
        else $error("boot start not a single pulse at release");
    a_soft_cpu: assert property (
        cpu_fire |=> cpu_cnt_reg == CW'(SOFT_RST_CYCLES))
        else $error("CPU reset request not taken");
    a_cpu_keep: assert property (
        cpu_fire |=> ##1 cpu_rst_reg && !mem_clr_reg)
        else $error("CPU reset lost memory or did not reset");
    a_dev_hard: assert property (s_dev_req |=> s_dev_hold)
        else $error("device reset differs from hard reset");
    a_boot_f00: assert property (
        release_now && trit == `PM_F00 |=>
        BOOT_CFG.source == boot_strap_pkg::BOOT_SYNC_MUX)
        else $error("sync muxed boot not selected");
    a_boot_spi: assert property (
        release_now && trit == `PM_0F1 |=>
        BOOT_CFG.source == boot_strap_pkg::BOOT_SPI &&
        BOOT_CFG.usb_fallback)
        else $error("SPI boot with fallback not selected");
    a_freq_xtal: assert property (
        release_now && sync_reg[2:0] == `FS_XTAL |=> BOOT_CFG.ref_crystal)
        else $error("crystal not selected");
    a_pll_rate: assert property (
        BOOT_START && cap_reg.freq == `FS_EXT52 |->
        BOOT_CFG.pll_mult == `PLL_MULT_VAL &&
        BOOT_CFG.pll_prediv == `PREDIV_52)
        else $error("PLL factors do not follow reference");
    a_cap_hold: assert property (
        !glob && !release_now |=> $stable(cap_reg) && $stable(BOOT_CFG))
        else $error("captured straps changed outside reset");

endmodule : boot_strap_reset_clock_select

/* File: verification/board_strap_model.sv */
// Board model: strap pins seen through pull-up and pull-down reads, the
// hard reset pin and the frequency straps. Assumes the bench sets codes.
`timescale 1ns/1ps

module board_strap_model (
    input  wire logic       clk,
    input  wire logic [5:0] trits,        // Strap levels, two bits each
    input  wire logic [2:0] freq,         // Frequency strap setting
    input  wire logic       reset_req,    // Hold the reset pin low
    output logic            hard_reset_n, // Hard reset pin
    output logic [2:0]      pu_read,      // Straps read with pull-up
    output logic [2:0]      pd_read,      // Straps read with pull-down
    output logic [2:0]      freq_pins     // Frequency strap pins
);
    // Pins carry defined levels before the first edge
    initial {hard_reset_n, pu_read, pd_read, freq_pins} = 10'h0;

    // Pins follow the board settings just after each edge
    always @(posedge clk)
    begin
        hard_reset_n <= !reset_req;
        freq_pins    <= freq;
        for (int i = 0; i < 3; i++)
        begin
            // Floating strap: pull-up reads high, pull-down reads low
            pu_read[i] <= trits[2*i +: 2] != 2'h0;
            pd_read[i] <= trits[2*i +: 2] == 2'h1;
        end
    end
endmodule : board_strap_model

/* File: verification/boot_strap_reset_clock_select_tb.sv */
// Bench for the strap loader: boot table, frequency table, soft resets.
// Assumes the board model and the design package are compiled first.
`timescale 1ns/1ps
`include "boot_strap_defines.svh"

module boot_strap_reset_clock_select_tb;
    localparam int SOFT = 4;  // Shortened soft reset pulse
    localparam logic [5:0] CODES [7] = '{`PM_F00, `PM_F01, `PM_F0F,
        `PM_F11, `PM_F1F, `PM_1FF, `PM_0F1};
    localparam logic [2:0] FSEL [5] = '{`FS_XTAL, `FS_EXT19, `FS_EXT26,
        `FS_EXT38, `FS_EXT52};
    logic        sys_clk = 1'b0;   // Bench clock
    logic        rst = 1'b1;       // System reset
    logic        reset_req = 1'b0; // Board hard reset request
    logic [5:0]  trits = `PM_F11;  // Board boot straps
    logic [2:0]  freq = `FS_XTAL;  // Board frequency straps
    logic        hsel = 1'b0;      // Bus signals
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = `HSIZE_WORD;
    logic        hard_reset_n;
    logic [2:0]  pu;
    logic [2:0]  pd;
    logic [2:0]  fpins;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        cpu_reset;
    logic        mem_clear;
    logic        io_hiz;
    logic        boot_start;
    boot_strap_pkg::boot_cfg_t cfg;  // Configuration out
    boot_strap_pkg::boot_cfg_t held; // Configuration kept for compare
    int          fail_count = 0;
    int          checks_done = 0;
    int          seed = 32'h9ffb;

    // Clock of 100 ns period
    always #50 sys_clk = !sys_clk;

    board_strap_model board_u (.clk(sys_clk), .trits(trits), .freq(freq),
        .reset_req(reset_req), .hard_reset_n(hard_reset_n), .pu_read(pu),
        .pd_read(pd), .freq_pins(fpins));

    boot_strap_reset_clock_select #(.SOFT_RST_CYCLES(SOFT)) dut_u (
        .SYS_CLK(sys_clk), .RST(rst), .HARD_RESET_N(hard_reset_n),
        .BOOT_MODE_STRAPS_PU(pu), .BOOT_MODE_STRAPS_PD(pd),
        .REF_FREQ_SELECT_STRAPS(fpins), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .CPU_RESET(cpu_reset), .MEM_CLEAR(mem_clear),
        .IO_HIZ(io_hiz), .BOOT_START(boot_start), .BOOT_CFG(cfg));

    // Compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One single word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : bus

    // Expected boot source and fallback flag
    function automatic logic [3:0] exp_boot(input logic [5:0] b);
        case (b)
            `PM_F00: return {boot_strap_pkg::BOOT_SYNC_MUX, 1'b0};
            `PM_F01: return {boot_strap_pkg::BOOT_ASYNC_MUX, 1'b0};
            `PM_F0F: return {boot_strap_pkg::BOOT_ASYNC_SRAM, 1'b0};
            `PM_F1F: return {boot_strap_pkg::BOOT_I2C, 1'b1};
            `PM_1FF: return {boot_strap_pkg::BOOT_I2C, 1'b0};
            `PM_0F1: return {boot_strap_pkg::BOOT_SPI, 1'b1};
            default: return {boot_strap_pkg::BOOT_USB, 1'b0};
        endcase
    endfunction : exp_boot

    // Expected PLL predivider for a frequency code
    function automatic logic [7:0] exp_div(input logic [2:0] f);
        case (f)
            `FS_EXT26: return `PREDIV_26;
            `FS_EXT38: return `PREDIV_38;
            `FS_EXT52: return `PREDIV_52;
            default:   return `PREDIV_19;
        endcase
    endfunction : exp_div

    // Check outputs and status against the captured straps
    task automatic check_cfg(input logic [5:0] b, input logic [2:0] f);
        logic [3:0]  e;
        logic [31:0] q;
        logic        ok;
        e  = exp_boot(b);
        ok = f == 3'h0 || f[2];
        chk({29'h0, cfg.source}, {29'h0, e[3:1]});
        chk({31'h0, cfg.usb_fallback}, {31'h0, e[0]});
        chk({30'h0, cfg.ref_crystal, cfg.ref_valid},
            {30'h0, !f[2], ok});
        chk({14'h0, cfg.pll_mult, cfg.pll_prediv},
            {14'h0, `PLL_MULT_VAL, exp_div(f)});
        bus(1'b0, `REG_STAT, 32'h0, q);
        chk(q, {17'h0, f, b, e, !f[2], ok});
        chk({30'h0, io_hiz, cpu_reset}, 32'h0);
    endtask : check_cfg

    // Hard reset through the board pin, then check the new boot setup
    task automatic hard_boot(input logic [5:0] b, input logic [2:0] f);
        int n;
        n = 0;
        reset_req <= 1'b1;
        trits     <= b;
        freq      <= f;
        repeat (6) @(posedge sys_clk);
        chk({31'h0, io_hiz}, 32'h1);
        reset_req <= 1'b0;
        // Wait for the boot pulse; running out of time is a mismatch
        while (boot_start !== 1'b1 && n < 40)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk({31'h0, boot_start}, 32'h1);
        check_cfg(b, f);
    endtask : hard_boot

    // Print counts and verdict, then stop
    task automatic wrap_up;
        $display("counts: checks=%0d bad=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        wrap_up();
    end

    // Main test sequence
    initial
    begin
        logic [5:0]  b;
        logic [2:0]  f;
        logic [31:0] q;
        int          n;
        int          m;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        // Every boot code, every clock code, then random strap mixes
        for (int i = 0; i < 16; i++)
        begin
            b = CODES[i % 7];
            if (i >= 7)
                for (int j = 0; j < 3; j++)
                    b[2*j +: 2] = 2'({$random(seed)} % 3);
            f = (i < 5) ? FSEL[i] : 3'($random(seed));
            hard_boot(b, f);
        end
        $display("test boot table done");
        // Straps move after capture: outputs must hold
        held = cfg;
        trits <= `PM_0F1;
        freq  <= `FS_EXT52;
        repeat (10) @(posedge sys_clk);
        chk({8'h0, cfg}, {8'h0, held});
        // CPU-only soft reset keeps memory and configuration
        bus(1'b1, `REG_CTRL, 32'h1, q);
        n = 0;
        m = 0;
        repeat (SOFT + 6)
        begin
            @(posedge sys_clk);
            n += (cpu_reset === 1'b1);
            m += (mem_clear !== 1'b0 || io_hiz !== 1'b0);
        end
        chk(n, SOFT);
        chk(m, 0);
        chk({8'h0, cfg}, {8'h0, held});
        $display("test cpu reset done");
        // Whole-device soft reset acts as hard reset and recaptures
        bus(1'b1, `REG_CTRL, 32'h2, q);
        // Control reads back the pending device reset
        bus(1'b0, `REG_CTRL, 32'h0, q);
        chk(q, 32'h2);
        n = 0;
        while (mem_clear !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk({29'h0, mem_clear, io_hiz, cpu_reset}, 32'h7);
        n = 0;
        while (boot_start !== 1'b1 && n < 40)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk({31'h0, boot_start}, 32'h1);
        check_cfg(`PM_0F1, `FS_EXT52);
        $display("test device reset done");
        // Unmapped place reads zero
        bus(1'b1, 8'h10, 32'hffffffff, q);
        bus(1'b0, 8'h10, 32'h0, q);
        chk(q, 32'h0);
        $display("test unmapped done");
        wrap_up();
    end
endmodule : boot_strap_reset_clock_select_tb
